// ---- rtl/level_sync.sv ----
// three-stage input synchroniser that accepts a level once the last two stages agree
`timescale 1ns/1ps
module level_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // raw and settled levels
  input wire logic [W-1:0] raw,
  output logic [W-1:0] level
);
  logic [W-1:0] ff1; // first stage, read only by ff2
  logic [W-1:0] ff2; // second stage
  logic [W-1:0] ff3; // third stage

  // shift chain
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ff1 <= '0;
      ff2 <= '0;
      ff3 <= '0;
    end else begin
      ff1 <= raw;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  // accept a bit only when stages two and three agree
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      level <= '0;
    end else begin
      level <= (ff2 & ~(ff2 ^ ff3)) | (level & (ff2 ^ ff3));
    end
  end
endmodule : level_sync

// ---- rtl/sysclk_flash_pkg.sv ----
// constants, field layout and state types for clock select and flash wait control
package sysclk_flash_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CLOCK_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_FLASH_WAIT = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PE_CMD = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;
  // clock source select codes
  localparam logic [1:0] SEL_WAKEUP = 2'h0;
  localparam logic [1:0] SEL_RESERVED = 2'h1;
  localparam logic [1:0] SEL_PRESCALE = 2'h2;
  localparam logic [1:0] SEL_DIRECT = 2'h3;
  // clock control fields
  localparam int CC_SEL_LSB = 0;
  localparam int CC_BYPASS_BIT = 2;
  localparam int CC_OSCSRC_BIT = 3;
  localparam int CC_DIV_LSB = 4;
  localparam int DIV_W = 10;
  // flash wait fields
  localparam int FW_COUNT_LSB = 0;
  localparam int FW_COUNT_W = 4;
  localparam int FW_EXT_BIT = 4;
  localparam int FW_SAFE_ACCESS_AFTER_RESET_BIT = 5;
  localparam logic [FW_COUNT_W-1:0] FW_COUNT_RESET = 4'h4;
  // program/erase command fields
  localparam int MOD_COUNT = 5;
  localparam int PE_MASK_LSB = 0;
  localparam int PE_ERASE_BIT = 5;
  localparam logic [MOD_COUNT-1:0] MOD4_MASK = 5'h10;
  // status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_REFUSED_BIT = 1;
  localparam int ST_PROT_BIT = 2;
  localparam int ST_SEL_LSB = 4;
  localparam int ST_BYPASS_BIT = 6;
  localparam int ST_OSCSRC_BIT = 7;
  localparam int ST_DIV_LSB = 8;
  localparam int ST_MODS_LSB = 20;
  // source level vector positions
  localparam int SRC_DIRECT = 0;
  localparam int SRC_CRYSTAL = 1;
  localparam int SRC_INTERNAL = 2;
  localparam int SRC_WAKEUP = 3;
  localparam int SRC_PLL = 4;
  localparam int SRC_COUNT = 5;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned ERASE_TIME_NS = 8_000_000;
  localparam int unsigned PROG_TIME_NS = 3_500_000;
  localparam int unsigned ERASE_CYCLES = ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 20;
  // state types
  typedef enum logic [2:0] {FA_IDLE = 3'b001, FA_WAIT = 3'b010, FA_ACK = 3'b100} fa_state_t;
  typedef enum logic [1:0] {PE_IDLE = 2'b01, PE_RUN = 2'b10} pe_state_t;
endpackage : sysclk_flash_pkg

// ---- rtl/sysclk_select_flash_wait.sv ----
// system clock source selection, prescaler and flash wait/program-erase control
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module sysclk_select_flash_wait
  import sysclk_flash_pkg::*;
#(
  parameter int unsigned ERASE_COUNT = ERASE_CYCLES,
  parameter int unsigned PROG_COUNT = PROG_CYCLES,
  parameter int unsigned OVERHEAD_COUNT = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock source pins
  input wire logic direct_clock_input,
  input wire logic crystal_input,
  input wire logic internal_clock,
  input wire logic wakeup_clock,
  input wire logic pll_clock,
  // generated clock and loop control
  output logic sysclk_out,
  output logic pll_enable,
  // flash access port
  input wire logic flash_req,
  input wire logic flash_seq,
  input wire logic flash_cached,
  input wire logic cache_hit,
  output logic flash_ack,
  // program/erase side
  input wire logic [MOD_COUNT-1:0] flash_read_modules,
  output logic [MOD_COUNT-1:0] pe_modules,
  output logic pe_busy,
  output logic pe_done,
  output logic flash_protect_active
);
  logic [SRC_COUNT-1:0] src_lvl; // settled source levels
  logic [1:0] clock_source_select; // requested source
  logic oscillator_bypass; // requested bypass
  logic osc_source; // 1 internal, 0 crystal
  logic [DIV_W-1:0] prescaler_divider_field; // requested divider
  logic [1:0] act_sel; // source in use
  logic act_bypass; // bypass in use
  logic act_src; // oscillator in use
  logic [DIV_W-1:0] act_div; // divider in use
  logic [DIV_W-1:0] div_cnt; // oscillator edge counter
  logic prev_lvl; // previous source level
  logic [FW_COUNT_W-1:0] flash_wait_count; // access wait states
  logic flash_wait_extension; // extra wait state
  logic safe_access_after_reset; // safe default after reset
  logic pe_refused; // sticky refusal flag
  logic pe_erase; // running op is erase
  logic [TIMER_W-1:0] pe_timer; // op countdown
  logic [FW_COUNT_W:0] wait_cnt; // access wait countdown
  fa_state_t fa_state; // access state
  fa_state_t next_fa_state;
  pe_state_t pe_state; // program/erase state

  // source pins settle through three stages
  level_sync #(.W(SRC_COUNT)) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .raw({pll_clock, wakeup_clock, internal_clock, crystal_input, direct_clock_input}),
    .level(src_lvl)
  );

  // source level for a given selection
  function automatic logic pick_src(input logic [1:0] sel, input logic byp, input logic osrc,
                                    input logic [SRC_COUNT-1:0] lv);
    logic r;
    r = 1'b0;
    unique case (sel)
      SEL_DIRECT: r = lv[SRC_DIRECT];
      SEL_WAKEUP: r = lv[SRC_WAKEUP];
      SEL_PRESCALE: r = byp ? (osrc ? lv[SRC_INTERNAL] : lv[SRC_CRYSTAL]) : lv[SRC_PLL];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : pick_src

  // apb decode
  logic access; // access phase
  logic wr_en; // write takes effect
  logic mapped; // address hits a register
  logic [DATA_W-1:0] rd_mux; // read value
  assign access = psel & penable;
  assign wr_en = access & pready & pwrite;
  assign mapped = (paddr == ADDR_CLOCK_CTRL) || (paddr == ADDR_FLASH_WAIT) ||
                  (paddr == ADDR_PE_CMD) || (paddr == ADDR_STATUS);

  // read multiplexer, reserved bits zero
  always_comb begin
    rd_mux = '0;
    if (paddr == ADDR_CLOCK_CTRL) begin
      rd_mux[CC_SEL_LSB +: 2] = clock_source_select;
      rd_mux[CC_BYPASS_BIT] = oscillator_bypass;
      rd_mux[CC_OSCSRC_BIT] = osc_source;
      rd_mux[CC_DIV_LSB +: DIV_W] = prescaler_divider_field;
    end else if (paddr == ADDR_FLASH_WAIT) begin
      rd_mux[FW_COUNT_LSB +: FW_COUNT_W] = flash_wait_count;
      rd_mux[FW_EXT_BIT] = flash_wait_extension;
      rd_mux[FW_SAFE_ACCESS_AFTER_RESET_BIT] = safe_access_after_reset;
    end else if (paddr == ADDR_STATUS) begin
      rd_mux[ST_BUSY_BIT] = pe_busy;
      rd_mux[ST_REFUSED_BIT] = pe_refused;
      rd_mux[ST_PROT_BIT] = flash_protect_active;
      rd_mux[ST_SEL_LSB +: 2] = act_sel;
      rd_mux[ST_BYPASS_BIT] = act_bypass;
      rd_mux[ST_OSCSRC_BIT] = act_src;
      rd_mux[ST_DIV_LSB +: DIV_W] = act_div;
      rd_mux[ST_MODS_LSB +: MOD_COUNT] = pe_modules;
    end
  end

  // one wait cycle, registered answer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (access && !pready) begin
      pready <= 1'b1;
      pslverr <= !mapped;
      prdata <= pwrite ? '0 : rd_mux;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
  end

  // clock control register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      clock_source_select <= SEL_WAKEUP;
      oscillator_bypass <= 1'b0;
      osc_source <= 1'b0;
      prescaler_divider_field <= '0;
    end else if (wr_en && paddr == ADDR_CLOCK_CTRL) begin
      clock_source_select <= pwdata[CC_SEL_LSB +: 2];
      oscillator_bypass <= pwdata[CC_BYPASS_BIT];
      osc_source <= pwdata[CC_OSCSRC_BIT];
      prescaler_divider_field <= pwdata[CC_DIV_LSB +: DIV_W];
    end
  end

  // flash wait register; software picks values for the frequency
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flash_wait_count <= FW_COUNT_RESET;
      flash_wait_extension <= 1'b0;
      safe_access_after_reset <= 1'b0;
    end else if (wr_en && paddr == ADDR_FLASH_WAIT) begin
      flash_wait_count <= pwdata[FW_COUNT_LSB +: FW_COUNT_W];
      flash_wait_extension <= pwdata[FW_EXT_BIT];
      safe_access_after_reset <= pwdata[FW_SAFE_ACCESS_AFTER_RESET_BIT];
    end
  end

  // clock switching terms
  logic cur_lvl; // active source level
  logic new_lvl; // requested source level
  logic prescaled; // active path divides
  logic new_div; // requested path divides
  logic pending; // request differs from active
  logic switch_now; // safe moment to switch
  logic rise; // oscillator rising edge
  logic [DIV_W-1:0] next_cnt; // edge counter next
  logic [DIV_W:0] half; // high phase length
  assign cur_lvl = pick_src(act_sel, act_bypass, act_src, src_lvl);
  assign new_lvl = pick_src(clock_source_select, oscillator_bypass, osc_source, src_lvl);
  assign prescaled = (act_sel == SEL_PRESCALE) && act_bypass && (act_div != '0);
  assign new_div = (clock_source_select == SEL_PRESCALE) && oscillator_bypass && (prescaler_divider_field != '0);
  assign pending = {clock_source_select, oscillator_bypass, osc_source, prescaler_divider_field} !=
                   {act_sel, act_bypass, act_src, act_div};
  assign switch_now = pending && (clock_source_select != SEL_RESERVED) && !sysclk_out &&
                      (new_div || !new_lvl);
  assign rise = cur_lvl && !prev_lvl;
  assign next_cnt = (div_cnt == act_div) ? '0 : div_cnt + 1'b1;
  assign half = ({1'b0, act_div} + (DIV_W+1)'(2)) >> 1;

  // active configuration follows request only at a low phase
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      act_sel <= SEL_WAKEUP;
      act_bypass <= 1'b0;
      act_src <= 1'b0;
      act_div <= '0;
    end else if (switch_now) begin
      act_sel <= clock_source_select;
      act_bypass <= oscillator_bypass;
      act_src <= osc_source;
      act_div <= prescaler_divider_field;
    end
  end

  // edge counter and source history
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= '0;
      prev_lvl <= 1'b0;
    end else if (switch_now) begin
      div_cnt <= prescaler_divider_field; // start at end of a period, output low
      prev_lvl <= new_lvl;
    end else begin
      prev_lvl <= cur_lvl;
      if (rise) begin
        div_cnt <= next_cnt;
      end
    end
  end

  // generated clock and loop enable
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sysclk_out <= 1'b0;
      pll_enable <= 1'b0;
    end else begin
      pll_enable <= (act_sel == SEL_PRESCALE) && !act_bypass;
      if (switch_now) begin
        sysclk_out <= 1'b0;
      end else if (!prescaled) begin
        sysclk_out <= cur_lvl;
      end else if (rise) begin
        sysclk_out <= {1'b0, next_cnt} < half;
      end
    end
  end

  // access wait selection
  logic [FW_COUNT_W:0] req_wait; // waits for a new access
  always_comb begin
    if (flash_cached) begin
      req_wait = cache_hit ? '0 : (FW_COUNT_W+1)'(1);
    end else if (flash_seq) begin
      req_wait = '0;
    end else begin
      req_wait = {1'b0, flash_wait_count} + {{FW_COUNT_W{1'b0}}, flash_wait_extension};
    end
  end

  // access state machine next state
  always_comb begin
    next_fa_state = fa_state;
    unique case (fa_state)
      FA_IDLE: if (flash_req) next_fa_state = (req_wait == '0) ? FA_ACK : FA_WAIT;
      FA_WAIT: if (wait_cnt == (FW_COUNT_W+1)'(1)) next_fa_state = FA_ACK;
      FA_ACK: next_fa_state = FA_IDLE;
      default: next_fa_state = FA_IDLE;
    endcase
  end

  // access state, countdown and acknowledge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fa_state <= FA_IDLE;
      wait_cnt <= '0;
      flash_ack <= 1'b0;
    end else begin
      fa_state <= next_fa_state;
      flash_ack <= next_fa_state == FA_ACK;
      if (fa_state == FA_IDLE) begin
        wait_cnt <= req_wait;
      end else if (fa_state == FA_WAIT) begin
        wait_cnt <= wait_cnt - 1'b1;
      end
    end
  end

  // program/erase admission
  logic pe_wr; // command written
  logic [MOD_COUNT-1:0] cmd_mask; // requested modules
  logic pe_ok; // command admissible
  assign pe_wr = wr_en && paddr == ADDR_PE_CMD;
  assign cmd_mask = pwdata[PE_MASK_LSB +: MOD_COUNT];
  assign pe_ok = (pe_state == PE_IDLE) && (cmd_mask != '0) && ((cmd_mask & flash_read_modules) == '0) &&
                 (($countones(flash_read_modules) <= 1) || (cmd_mask == MOD4_MASK));

  // program/erase engine
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pe_state <= PE_IDLE;
      pe_timer <= '0;
      pe_modules <= '0;
      pe_erase <= 1'b0;
      pe_busy <= 1'b0;
      pe_done <= 1'b0;
    end else begin
      pe_done <= 1'b0;
      unique case (pe_state)
        PE_IDLE: begin
          if (pe_wr && pe_ok) begin
            pe_state <= PE_RUN;
            pe_busy <= 1'b1;
            pe_modules <= cmd_mask;
            pe_erase <= pwdata[PE_ERASE_BIT];
            pe_timer <= pwdata[PE_ERASE_BIT] ? TIMER_W'(ERASE_COUNT + OVERHEAD_COUNT) :
                                               TIMER_W'(PROG_COUNT + OVERHEAD_COUNT);
          end
        end
        PE_RUN: begin
          if (pe_timer == TIMER_W'(1)) begin
            pe_state <= PE_IDLE;
            pe_busy <= 1'b0;
            pe_done <= 1'b1;
            pe_modules <= '0;
          end
          pe_timer <= pe_timer - 1'b1;
        end
      endcase
    end
  end

  // refusal flag: set wins over write-one clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pe_refused <= 1'b0;
    end else if (pe_wr && !pe_ok) begin
      pe_refused <= 1'b1;
    end else if (wr_en && paddr == ADDR_STATUS && pwdata[ST_REFUSED_BIT]) begin
      pe_refused <= 1'b0;
    end
  end

  // no protection mechanism exists: delivered unprotected
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flash_protect_active <= 1'b0;
    end else begin
      flash_protect_active <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_idle_req;
    fa_state == FA_IDLE && flash_req;
  endsequence
  property p_direct;
    (act_sel == SEL_DIRECT && !pending) |=> sysclk_out == $past(src_lvl[SRC_DIRECT]);
  endproperty
  a_direct: assert property (p_direct) else $error("direct clock not followed");
  property p_wakeup;
    (act_sel == SEL_WAKEUP && !pending) |=> sysclk_out == $past(src_lvl[SRC_WAKEUP]);
  endproperty
  a_wakeup: assert property (p_wakeup) else $error("wakeup clock not followed");
  property p_factor_one;
    (act_sel == SEL_PRESCALE && act_bypass && act_div == '0 && !pending) |=> sysclk_out == $past(cur_lvl);
  endproperty
  a_factor_one: assert property (p_factor_one) else $error("factor one not pass-through");
  property p_cnt_range;
    prescaled |-> div_cnt <= act_div;
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("divider count beyond factor");
  property p_pll;
    (act_sel == SEL_PRESCALE && !act_bypass) [*2] |-> pll_enable;
  endproperty
  a_pll: assert property (p_pll) else $error("loop not enabled");
  property p_hit;
    s_idle_req ##0 (flash_cached && cache_hit) |=> flash_ack;
  endproperty
  a_hit: assert property (p_hit) else $error("cache hit not immediate");
  property p_miss;
    s_idle_req ##0 (flash_cached && !cache_hit) |=> !flash_ack ##1 flash_ack;
  endproperty
  a_miss: assert property (p_miss) else $error("cache miss not one wait");
  property p_seq;
    s_idle_req ##0 (!flash_cached && flash_seq) |=> flash_ack;
  endproperty
  a_seq: assert property (p_seq) else $error("sequential access waited");
  property p_no_read_clash;
    $rose(pe_busy) |-> (pe_modules & $past(flash_read_modules)) == '0;
  endproperty
  a_no_read_clash: assert property (p_no_read_clash) else $error("module under read started");
  property p_multi_read;
    ($rose(pe_busy) && $countones($past(flash_read_modules)) > 1) |-> pe_modules == MOD4_MASK;
  endproperty
  a_multi_read: assert property (p_multi_read) else $error("wrong module under multi read");
  property p_switch_low;
    switch_now |=> !sysclk_out;
  endproperty
  a_switch_low: assert property (p_switch_low) else $error("switch not at low phase");
  property p_timer;
    pe_busy |-> pe_timer <= TIMER_W'(ERASE_COUNT + OVERHEAD_COUNT);
  endproperty
  a_timer: assert property (p_timer) else $error("operation longer than limit");
endmodule : sysclk_select_flash_wait

// ---- tb/sysclk_select_flash_wait_bench.sv ----
// self-checking bench for clock select, flash waits and program/erase control
`timescale 1ns/1ps
module sysclk_select_flash_wait_bench
  import sysclk_flash_pkg::*;
;
  // shortened program/erase timing for simulation
  localparam int EC = 20;
  localparam int PC = 10;
  localparam int OC = 2;
  // clock and reset
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  // apb side
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  // source levels, indexed by the SRC_ positions
  logic [SRC_COUNT-1:0] src = '0;
  logic sysclk_out;
  logic pll_enable;
  // flash access and program/erase side
  logic flash_req = 1'b0;
  logic flash_seq = 1'b0;
  logic flash_cached = 1'b0;
  logic cache_hit = 1'b0;
  logic flash_ack;
  logic [MOD_COUNT-1:0] flash_read_modules = '0;
  logic [MOD_COUNT-1:0] pe_modules;
  logic pe_busy;
  logic pe_done;
  logic flash_protect_active;
  // bookkeeping
  int n_mismatch = 0;
  int num_checks = 0;
  int tick = 0;
  int cyc = 0;
  logic [DATA_W-1:0] rd;
  logic err;
  // prescaler table: divider field and oscillator choice
  logic [DIV_W-1:0] kdiv [4] = '{10'h000, 10'h001, 10'h002, 10'h3FF};
  logic kosc [4] = '{1'b0, 1'b0, 1'b1, 1'b0};

  // 40 MHz system clock
  always #12.5 sys_clk = ~sys_clk;

  // slow source clocks, each a different period
  always @(posedge sys_clk) begin
    tick <= tick + 1;
    src[SRC_DIRECT] <= (tick % 10) < 5;
    src[SRC_CRYSTAL] <= (tick % 8) < 4;
    src[SRC_INTERNAL] <= (tick % 12) < 6;
    src[SRC_WAKEUP] <= (tick % 14) < 7;
    src[SRC_PLL] <= (tick % 6) < 3;
  end

  sysclk_select_flash_wait #(.ERASE_COUNT(EC), .PROG_COUNT(PC), .OVERHEAD_COUNT(OC)) i_dut (
    .sys_clk(sys_clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .direct_clock_input(src[SRC_DIRECT]), .crystal_input(src[SRC_CRYSTAL]),
    .internal_clock(src[SRC_INTERNAL]), .wakeup_clock(src[SRC_WAKEUP]), .pll_clock(src[SRC_PLL]),
    .sysclk_out(sysclk_out), .pll_enable(pll_enable),
    .flash_req(flash_req), .flash_seq(flash_seq), .flash_cached(flash_cached),
    .cache_hit(cache_hit), .flash_ack(flash_ack),
    .flash_read_modules(flash_read_modules), .pe_modules(pe_modules), .pe_busy(pe_busy),
    .pe_done(pe_done), .flash_protect_active(flash_protect_active)
  );

  // verdict and end of run
  task automatic close_out();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // cut a hang short
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      n_mismatch++;
      $display("[FAIL] %0t timeout", $time);
      close_out();
    end
  end

  // value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // one apb transfer; read data and error land in rd and err
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // wait for the answer; only the bench timeout ends this
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one flash access; w is the expected number of wait cycles
  task automatic acc(input logic sq, input logic ch, input logic hit, input int w, input string m);
    int n;
    @(posedge sys_clk);
    flash_req <= 1'b1;
    flash_seq <= sq;
    flash_cached <= ch;
    cache_hit <= hit;
    @(posedge sys_clk);
    flash_req <= 1'b0;
    n = 0;
    #1;
    while (flash_ack !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(n, w, m);
  endtask : acc

  // source rises between two settled output rises must equal the factor
  task automatic gap(input int s, input int k, input string m);
    logic ps;
    logic po;
    int cnt;
    int r;
    int n;
    repeat (40) @(posedge sys_clk);
    ps = src[s];
    po = sysclk_out;
    cnt = 0;
    r = 0;
    n = 0;
    while (r < 3 && n < 40000) begin
      @(posedge sys_clk);
      #1;
      if (src[s] && !ps) cnt++;
      if (sysclk_out === 1'b1 && po === 1'b0) begin
        r++;
        if (r == 2) cnt = 0;
      end
      ps = src[s];
      po = sysclk_out;
      n++;
    end
    chk(cnt, k, m);
  endtask : gap

  // program/erase command with read mask rdm; ok says whether it must start
  task automatic pe(input logic [4:0] rdm, input logic [4:0] mask, input logic er, input logic ok, input string m);
    int n;
    int lim;
    lim = er ? EC + OC : PC + OC;
    flash_read_modules <= rdm;
    apb(1'b1, ADDR_PE_CMD, {26'h0, er, mask});
    @(posedge sys_clk);
    #1;
    n = 1;
    chk(pe_modules, ok ? mask : 5'h00, m);
    chk(pe_busy, ok, m);
    if (ok) begin
      while (pe_done !== 1'b1 && n < 100) begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      chk(n, lim, m);
    end
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[ST_REFUSED_BIT], !ok, m);
    apb(1'b1, ADDR_STATUS, 32'h2);
    flash_read_modules <= '0;
  endtask : pe

  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    // reset values and an unmapped place
    apb(1'b0, ADDR_CLOCK_CTRL, 32'h0);
    chk(rd, 32'h0, "clock ctrl reset");
    apb(1'b0, ADDR_FLASH_WAIT, 32'h0);
    chk(rd, {28'h0, FW_COUNT_RESET}, "wait reset");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[ST_PROT_BIT], 1'b0, "protect bit");
    chk(flash_protect_active, 1'b0, "protect pin");
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1, "unmapped");
    gap(SRC_WAKEUP, 1, "wakeup");
    // flash wait states
    acc(1'b0, 1'b0, 1'b0, FW_COUNT_RESET, "nonseq reset");
    apb(1'b1, ADDR_FLASH_WAIT, 32'h34);
    acc(1'b0, 1'b0, 1'b0, 5, "nonseq ext");
    acc(1'b1, 1'b0, 1'b0, 0, "seq");
    acc(1'b1, 1'b1, 1'b0, 1, "miss");
    acc(1'b0, 1'b1, 1'b1, 0, "hit");
    // direct drive, then reserved code must leave it in place
    apb(1'b1, ADDR_CLOCK_CTRL, {30'h0, SEL_DIRECT});
    gap(SRC_DIRECT, 1, "direct");
    apb(1'b1, ADDR_CLOCK_CTRL, {30'h0, SEL_RESERVED});
    repeat (20) @(posedge sys_clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[5:4], SEL_DIRECT, "reserved held");
    // loop operation
    apb(1'b1, ADDR_CLOCK_CTRL, {30'h0, SEL_PRESCALE});
    gap(SRC_PLL, 1, "loop");
    chk(pll_enable, 1'b1, "loop enable");
    // prescaler operation, factors 1, 2, 3 and 1024
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_CLOCK_CTRL, {18'h0, kdiv[i], kosc[i], 1'b1, SEL_PRESCALE});
      gap(kosc[i] ? SRC_INTERNAL : SRC_CRYSTAL, int'(kdiv[i]) + 1, "prescale");
      chk(pll_enable, 1'b0, "loop off");
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[17:8], kdiv[i], "active divider");
    end
    // program and erase permissions and durations
    pe(5'h00, 5'h1F, 1'b0, 1'b1, "program all");
    pe(5'h01, 5'h1E, 1'b1, 1'b1, "erase others");
    pe(5'h02, 5'h02, 1'b0, 1'b0, "read module");
    pe(5'h03, 5'h04, 1'b0, 1'b0, "two reads");
    pe(5'h03, MOD4_MASK, 1'b1, 1'b1, "module four");
    close_out();
  end
endmodule : sysclk_select_flash_wait_bench
